// ---- inc/uocc_pkg.sv ----
`default_nettype none
package uocc_pkg;
	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [9:0] OFF_USB_FUNCTION_ADDRESS = 10'h000;
	localparam logic [9:0] OFF_POWER = 10'h001;
	localparam logic [9:0] OFF_TXF = 10'h002;
	localparam logic [9:0] OFF_RXF = 10'h004;
	localparam logic [9:0] OFF_TXE = 10'h006;
	localparam logic [9:0] OFF_RXE = 10'h008;
	localparam logic [9:0] OFF_USBF = 10'h00a;
	localparam logic [9:0] OFF_USBE = 10'h00b;
	localparam logic [9:0] OFF_FRAME = 10'h00c;
	localparam logic [9:0] OFF_INDEX = 10'h00e;
	localparam logic [9:0] OFF_TEST = 10'h00f;
	localparam logic [9:0] OFF_SESSION = 10'h060;
	localparam logic [9:0] OFF_ENDPOINT_COUNT_INFO = 10'h078;
	localparam logic [9:0] OFF_RAM_WIDTH_INFO = 10'h079;
	localparam logic [9:0] OFF_DELAY = 10'h07a;
	localparam logic [9:0] OFF_VBUS_PULSE_DURATION = 10'h07b;
	localparam logic [9:0] OFF_HSEOF = 10'h07c;
	localparam logic [9:0] OFF_FSEOF = 10'h07d;
	localparam logic [9:0] OFF_LSEOF = 10'h07e;
	localparam logic [9:0] OFF_RQPKT = 10'h300;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_POWER = 8'h20;
	localparam logic [15:0] RST_TXE = 16'hffff;
	localparam logic [15:0] RST_RXE = 16'hfffe;
	localparam logic [7:0] RST_USBE = 8'h06;
	localparam logic [7:0] RST_VBUS_PULSE_DURATION = 8'h3c;
	localparam logic [7:0] RST_HSEOF = 8'h80;
	localparam logic [7:0] RST_FSEOF = 8'h77;
	localparam logic [7:0] RST_LSEOF = 8'h72;
	localparam logic [7:0] RST_DELAY = 8'h00;
	// ------------------------------------------------------------
	// Power control field positions
	// ------------------------------------------------------------
	localparam int PW_ISO = 7;
	localparam int PW_SOFTCONN = 6;
	localparam int PW_HSEN = 5;
	localparam int PW_HSMODE = 4;
	localparam int PW_RESET = 3;
	localparam int PW_RESUME = 2;
	localparam int PW_SUSP = 1;
	localparam int PW_SUSPEN = 0;
	// Common event positions
	localparam int EV_VBERR = 7;
	localparam int EV_SESREQ = 6;
	localparam int EV_DETACH = 5;
	localparam int EV_ATTACH = 4;
	localparam int EV_SOF = 3;
	localparam int EV_RSTBAB = 2;
	localparam int EV_RESUME = 1;
	localparam int EV_SUSPEND = 0;
	// Test mode fields
	localparam int TM_FHOST = 7;
	localparam int TM_FFS = 5;
	localparam int TM_FHS = 4;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int RESUME_MIN_MS = 10;
	localparam int RESUME_MAX_MS = 15;
	localparam int RESUME_MAX_CYC = RESUME_MAX_MS * 1000 * CLK_MHZ;
	typedef enum logic [1:0] {UOCC_LS, UOCC_FS, UOCC_HS} uocc_speed_t;
	typedef struct packed {
		logic [9:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} uocc_bus_t;
	typedef struct packed {
		logic bus_reset;     // Reset signalling present (level)
		logic resume_seen;   // Resume signalling detected (pulse)
		logic suspend_seen;  // Suspend signalling detected (pulse)
		logic sof;           // New frame (pulse)
		logic babble;        // Babble detected (pulse)
		logic attach;        // Connect detected (pulse)
		logic detach;        // Disconnect / session end (pulse)
		logic sess_req;      // Session request seen (pulse)
		logic vbus_low;      // VBus below valid (level)
		logic a_device;      // We are the A device (level)
		logic hs_chirp_ok;   // High-speed handshake succeeded (pulse)
		logic in_token;      // IN token to this function (pulse)
		logic [10:0] frame;  // Last received frame number
	} uocc_link_t;
endpackage
`default_nettype wire

// ---- design/uocc_flag_bank.sv ----
`default_nettype none
module uocc_flag_bank #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] USED = '1
) (
	input wire logic ref_clk,             // System clock
	input wire logic reset_n,             // Async reset, active low
	input wire logic clk_en,              // Freezes state while low
	input wire logic [WIDTH-1:0] set_ev,  // Hardware events
	input wire logic clear_all,           // Read clears every flag
	output logic [WIDTH-1:0] flags        // Sticky flags
);
	// Set beats the read-clear so an event in that cycle survives
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		if (USED[i]) begin : g_used
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n)
					flags[i] <= 1'b0;
				else if (clk_en)
					flags[i] <= set_ev[i] | (flags[i] & ~clear_all);
			end
		end else begin : g_unused
			assign flags[i] = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- design/uocc_common_ctrl.sv ----
// Functional notes
// - ISO update holds a loaded packet until SOF; early IN sends zero-length packet.
// - Soft connect bit enables D+/D- drivers; cleared means tri-stated.
// - High-speed enable allows HS negotiation at bus reset; status bit reports success.
// - Reset status bit follows bus reset signalling.
// - Resume bit drives resume; software clears after 10 ms, before 15 ms.
// - Suspend bit: software in host, hardware in peripheral; cleared by read or resume.
// - Transceiver suspend output only when its enable bit is set.
// - Sixteen read-only transmit endpoint flags, set by hardware.
// - Receive flags for endpoints 1 to 15; bit 0 reads zero.
// - Each endpoint flag has a writable enable; receive enable bit 0 reads zero.
// - As A device, VBus falling below valid in session sets error flag.
// - As A device, session request signalling sets its flag.
// - Detach flag on host disconnect or peripheral session end.
// - Attach flag in host mode; SOF flag every new frame.
// - Bit 2: bus reset in peripheral, babble in host after first SOF.
// - Resume flag while suspended; suspend flag in peripheral mode only.
// - One enable bit per common flag at the same position.
// - Frame register shows last frame number in low eleven bits.
// - Four-bit index selects endpoint register window 10h to 19h.
// - Forced host enters host with session, ignores line inputs; forced speed bits.
// - VBus pulse length and EOF buffer registers with documented defaults.
//
// Strobed register access is this design's own decision.
`default_nettype none
module uocc_common_ctrl
	import uocc_pkg::*;
#(
	parameter int NUM_EP = 16,
	parameter logic [7:0] EP_INFO = 8'hff,     // Arbitrary default
	parameter logic [7:0] RAM_INFO = 8'h00,    // Arbitrary default
	parameter int RESUME_LIMIT = RESUME_MAX_CYC
) (
	input wire logic ref_clk,                   // 100 MHz system clock
	input wire logic reset_n,                   // Async reset, active low
	input wire logic clk_en,                    // Freezes all state while low
	input wire uocc_pkg::uocc_bus_t bus,        // Register request
	output logic [15:0] rdata,                  // Read data, cycle after strobe
	input wire uocc_pkg::uocc_link_t link_raw,  // Link events from the line logic
	input wire logic [15:0] tx_ep_event,        // Transmit endpoint events
	input wire logic [15:0] rx_ep_event,        // Receive endpoint events
	input wire logic id_pin_input,              // ID pin, 1 = B side
	input wire logic phy_host_detach_status,    // PHY disconnect status
	input wire logic tx_packet_loaded,          // Endpoint packet is ready
	output logic send_packet,                   // Release loaded packet
	output logic send_zero_length,              // Answer IN with empty packet
	output logic dp_dm_oe_n,                    // Line drivers enabled when low
	output logic transceiver_suspend_output,    // Suspend to transceiver
	output logic resume_drive,                  // Drive resume signalling
	output logic host_mode,                     // Acting as host
	output logic [1:0] link_speed,              // Chosen speed
	output logic [3:0] endpoint_select,         // Indexed window selector
	output logic resume_overrun,                // Resume held past its limit
	output logic irq                            // Interrupt request
);
	import uocc_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers (line side is asynchronous)
	// ------------------------------------------------------------
	uocc_link_t link_s1, link;
	logic id_s1, id_s, det_s1, det_s;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_s1 <= '0;
			link <= '0;
			{id_s1, id_s, det_s1, det_s} <= 4'h0;
		end else if (clk_en) begin
			link_s1 <= link_raw;
			link <= link_s1;
			{id_s1, det_s1} <= {id_pin_input, phy_host_detach_status};
			{id_s, det_s} <= {id_s1, det_s1};
		end
	end

	// Frame number is a word from another domain: take it only once two
	// samples agree, so a skewed update is never shown to software
	logic [10:0] frame_prev, frame_num;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_prev <= 11'h000;
			frame_num <= 11'h000;
		end else if (clk_en) begin
			frame_prev <= link.frame;
			if (link.frame == frame_prev) frame_num <= link.frame;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [6:0] func_addr;
	logic [7:0] power;
	logic [15:0] tx_en, rx_en;
	logic [7:0] usb_en, test_mode, delay_info, vbus_pulse_duration, hs_eof, fs_eof, ls_eof;
	logic session;
	logic sof_sent, bus_reset_d, iso_wait, resume_d, held;
	logic [15:0] rq_count [1:15];
	logic [31:0] resume_cnt;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
		return a == off;
	endfunction
	wire wr = bus.wr & clk_en;
	wire rd = bus.rd & clk_en;
	wire wr_power = wr & hit(bus.addr, OFF_POWER);
	wire rd_usbf = rd & hit(bus.addr, OFF_USBF);
	wire rq_hit = (bus.addr[9:5] == OFF_RQPKT[9:5]) & ~bus.addr[0] & (bus.addr[4:1] != 4'h0);
	wire [3:0] rq_ep = bus.addr[4:1];
	wire forced = test_mode[TM_FHOST];
	// forced host ignores ID and line inputs, host only while session
	wire is_host = forced ? session : (session & ~id_s);
	wire resume_set_sw = wr_power & bus.wdata[PW_RESUME] & ~power[PW_RESUME];

	// ------------------------------------------------------------
	// Common event sources
	// ------------------------------------------------------------
	logic [7:0] usb_ev;
	always_comb begin
		usb_ev = 8'h00;
		usb_ev[EV_VBERR] = link.a_device & session & link.vbus_low;
		usb_ev[EV_SESREQ] = link.a_device & link.sess_req;
		usb_ev[EV_DETACH] = link.detach | (is_host & ~forced & det_s);
		usb_ev[EV_ATTACH] = is_host & link.attach;
		usb_ev[EV_SOF] = link.sof;
		// Bit 2 meaning swaps with mode; babble ignored before any SOF
		usb_ev[EV_RSTBAB] = is_host ? (link.babble & sof_sent)
			: (link.bus_reset & ~bus_reset_d);
		usb_ev[EV_RESUME] = link.resume_seen & power[PW_SUSP];
		usb_ev[EV_SUSPEND] = ~is_host & link.suspend_seen;
	end

	logic [15:0] tx_flags, rx_flags;
	logic [7:0] usb_flags;
	uocc_flag_bank #(.WIDTH(16), .USED(16'hffff)) u_tx (
		.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
		.set_ev(tx_ep_event), .clear_all(rd & hit(bus.addr, OFF_TXF)),
		.flags(tx_flags));
	uocc_flag_bank #(.WIDTH(16), .USED(16'hfffe)) u_rx (
		.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
		.set_ev(rx_ep_event), .clear_all(rd & hit(bus.addr, OFF_RXF)),
		.flags(rx_flags));
	uocc_flag_bank #(.WIDTH(8), .USED(8'hff)) u_usb (
		.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
		.set_ev(usb_ev), .clear_all(rd_usbf),
		.flags(usb_flags));

	// ------------------------------------------------------------
	// Power control bits
	// ------------------------------------------------------------
	wire suspend_set = is_host ? (wr_power & bus.wdata[PW_SUSP]) : link.suspend_seen;
	wire suspend_clr = rd_usbf | resume_set_sw;
	wire remote_resume = is_host & power[PW_SUSP] & link.resume_seen;
	logic [7:0] next_power;
	always_comb begin
		next_power = power;
		if (wr_power) begin
			next_power[PW_ISO] = bus.wdata[PW_ISO];
			next_power[PW_SOFTCONN] = bus.wdata[PW_SOFTCONN];
			next_power[PW_HSEN] = bus.wdata[PW_HSEN];
			next_power[PW_RESUME] = bus.wdata[PW_RESUME];
			next_power[PW_SUSPEN] = bus.wdata[PW_SUSPEN];
		end
		if (remote_resume)
			next_power[PW_RESUME] = 1'b1;
		next_power[PW_RESET] = link.bus_reset;
		if (~session)
			next_power[PW_HSMODE] = 1'b0;
		else if (link.bus_reset & link.hs_chirp_ok & power[PW_HSEN])
			next_power[PW_HSMODE] = 1'b1;
		if (suspend_clr)
			next_power[PW_SUSP] = 1'b0;
		if (suspend_set)
			next_power[PW_SUSP] = 1'b1;
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			func_addr <= 7'h00;
			power <= RST_POWER;
			tx_en <= RST_TXE;
			rx_en <= RST_RXE;
			usb_en <= RST_USBE;
			endpoint_select <= 4'h0;
			test_mode <= 8'h00;
			session <= 1'b0;
			delay_info <= RST_DELAY;
			vbus_pulse_duration <= RST_VBUS_PULSE_DURATION;
			hs_eof <= RST_HSEOF;
			fs_eof <= RST_FSEOF;
			ls_eof <= RST_LSEOF;
		end else if (clk_en) begin
			power <= next_power;
			if (wr) begin
				if (hit(bus.addr, OFF_USB_FUNCTION_ADDRESS)) func_addr <= bus.wdata[6:0];
				if (hit(bus.addr, OFF_TXE)) tx_en <= bus.wdata;
				if (hit(bus.addr, OFF_RXE)) rx_en <= {bus.wdata[15:1], 1'b0};
				if (hit(bus.addr, OFF_USBE)) usb_en <= bus.wdata[7:0];
				if (hit(bus.addr, OFF_INDEX)) endpoint_select <= bus.wdata[3:0];
				if (hit(bus.addr, OFF_TEST)) test_mode <= bus.wdata[7:0];
				if (hit(bus.addr, OFF_SESSION)) session <= bus.wdata[0];
				if (hit(bus.addr, OFF_DELAY)) delay_info <= bus.wdata[7:0];
				if (hit(bus.addr, OFF_VBUS_PULSE_DURATION)) vbus_pulse_duration <= bus.wdata[7:0];
				if (hit(bus.addr, OFF_HSEOF)) hs_eof <= bus.wdata[7:0];
				if (hit(bus.addr, OFF_FSEOF)) fs_eof <= bus.wdata[7:0];
				if (hit(bus.addr, OFF_LSEOF)) ls_eof <= bus.wdata[7:0];
			end
		end
	end

	// Requested-packet counters, one per receive endpoint
	for (genvar e = 1; e < 16; e++) begin : g_rq
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n)
				rq_count[e] <= 16'h0000;
			else if (clk_en & wr & rq_hit & (rq_ep == 4'(e)))
				rq_count[e] <= bus.wdata;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		unique case (bus.addr)
			OFF_USB_FUNCTION_ADDRESS: rd_mux = {9'h000, func_addr};
			OFF_POWER: rd_mux = {8'h00, power};
			OFF_TXF: rd_mux = tx_flags;
			OFF_RXF: rd_mux = rx_flags;
			OFF_TXE: rd_mux = tx_en;
			OFF_RXE: rd_mux = rx_en;
			OFF_USBF: rd_mux = {8'h00, usb_flags};
			OFF_USBE: rd_mux = {8'h00, usb_en};
			OFF_FRAME: rd_mux = {5'h00, frame_num};
			OFF_INDEX: rd_mux = {12'h000, endpoint_select};
			OFF_TEST: rd_mux = {8'h00, forced ? det_s : test_mode[7], test_mode[6:0]};
			OFF_SESSION: rd_mux = {13'h0000, is_host, 1'b0, session};
			OFF_ENDPOINT_COUNT_INFO: rd_mux = {8'h00, EP_INFO};
			OFF_RAM_WIDTH_INFO: rd_mux = {8'h00, RAM_INFO};
			OFF_DELAY: rd_mux = {8'h00, delay_info};
			OFF_VBUS_PULSE_DURATION: rd_mux = {8'h00, vbus_pulse_duration};
			OFF_HSEOF: rd_mux = {8'h00, hs_eof};
			OFF_FSEOF: rd_mux = {8'h00, fs_eof};
			OFF_LSEOF: rd_mux = {8'h00, ls_eof};
			default: rd_mux = rq_hit ? rq_count[rq_ep] : 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// Line control and outputs
	// ------------------------------------------------------------
	wire [1:0] speed_sel = forced
		? (test_mode[TM_FHS] ? 2'(UOCC_HS) : test_mode[TM_FFS] ? 2'(UOCC_FS) : 2'(UOCC_LS))
		: (power[PW_HSMODE] ? 2'(UOCC_HS) : 2'(UOCC_FS));
	wire iso_hold = power[PW_ISO] & tx_packet_loaded & ~held;
	wire any_irq = |(tx_flags & tx_en) | |(rx_flags & rx_en) | |(usb_flags & usb_en);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 16'h0000;
			irq <= 1'b0;
			dp_dm_oe_n <= 1'b1;
			transceiver_suspend_output <= 1'b0;
			resume_drive <= 1'b0;
			host_mode <= 1'b0;
			link_speed <= 2'(UOCC_FS);
			send_packet <= 1'b0;
			send_zero_length <= 1'b0;
			sof_sent <= 1'b0;
			bus_reset_d <= 1'b0;
			held <= 1'b0;
			iso_wait <= 1'b0;
			resume_d <= 1'b0;
			resume_cnt <= 32'h0;
			resume_overrun <= 1'b0;
		end else if (clk_en) begin
			if (rd) rdata <= rd_mux;
			irq <= any_irq;
			dp_dm_oe_n <= ~power[PW_SOFTCONN];
			transceiver_suspend_output <= power[PW_SUSPEN] & power[PW_SUSP];
			resume_drive <= power[PW_RESUME];
			host_mode <= is_host;
			link_speed <= speed_sel;
			bus_reset_d <= link.bus_reset;
			sof_sent <= is_host & (sof_sent | link.sof);
			// SOF releases the held packet; IN before SOF gets an empty one
			iso_wait <= iso_hold & ~(iso_wait & link.sof);
			held <= tx_packet_loaded & (held | (iso_wait & link.sof));
			send_packet <= tx_packet_loaded & (~power[PW_ISO] | (iso_wait & link.sof));
			send_zero_length <= iso_wait & ~link.sof & link.in_token;
			resume_d <= power[PW_RESUME];
			resume_cnt <= power[PW_RESUME] ? resume_cnt + 32'h1 : 32'h0;
			if (power[PW_RESUME] & ~resume_d) resume_overrun <= 1'b0;
			else if (resume_cnt == 32'(RESUME_LIMIT)) resume_overrun <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_irq;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_en && any_irq |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missed");
	property p_rx0;
		@(posedge ref_clk) disable iff (!reset_n) rx_flags[0] == 1'b0 && rx_en[0] == 1'b0;
	endproperty
	a_rx0: assert property (p_rx0) else $error("rx bit 0 set");
	property p_susp_out;
		@(posedge ref_clk) disable iff (!reset_n)
		transceiver_suspend_output |-> $past(power[PW_SUSPEN]);
	endproperty
	a_susp_out: assert property (p_susp_out) else $error("suspend out unenabled");
	property p_soft;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_en |=> dp_dm_oe_n == !$past(power[PW_SOFTCONN]);
	endproperty
	a_soft: assert property (p_soft) else $error("soft connect wrong");
	property p_rst;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_en && link.bus_reset |=> power[PW_RESET];
	endproperty
	a_rst: assert property (p_rst) else $error("reset bit low");
	property p_susp_clr;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_en && rd_usbf && !suspend_set |=> !power[PW_SUSP];
	endproperty
	a_susp_clr: assert property (p_susp_clr) else $error("suspend not cleared");
	property p_zlp;
		@(posedge ref_clk) disable iff (!reset_n)
		send_zero_length |-> $past(iso_wait) && !send_packet;
	endproperty
	a_zlp: assert property (p_zlp) else $error("zero length out of place");
	property p_sof;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_en && link.sof |=> usb_flags[EV_SOF];
	endproperty
	a_sof: assert property (p_sof) else $error("sof flag missed");
	sequence s_iso_release;
		clk_en && iso_wait && link.sof && tx_packet_loaded;
	endsequence
	property p_iso_once;
		@(posedge ref_clk) disable iff (!reset_n)
		s_iso_release |=> send_packet && !iso_wait;
	endproperty
	a_iso_once: assert property (p_iso_once) else $error("iso packet not released once");
	property p_remote_res;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_en && remote_resume |=> power[PW_RESUME];
	endproperty
	a_remote_res: assert property (p_remote_res) else $error("remote resume not set");
endmodule
`default_nettype wire

// ---- testbench/uocc_line_model.sv ----
`default_nettype none
module uocc_line_model
	import uocc_pkg::*;
(
	input wire logic ref_clk,              // System clock
	input wire logic reset_n,              // Async reset, active low
	input wire uocc_pkg::uocc_link_t cmd,  // One-cycle event requests
	output var uocc_pkg::uocc_link_t link_raw  // Line events seen by the core
);
	timeunit 1ns;
	timeprecision 1ps;
	uocc_link_t hold_a;
	uocc_link_t hold_b;
	// Pulses last three cycles so the two-flop sync cannot miss one
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_a <= '0;
			hold_b <= '0;
		end else begin
			hold_a <= cmd;
			hold_b <= hold_a;
		end
	end
	always_comb begin
		link_raw = cmd | hold_a | hold_b;
		link_raw.frame = cmd.frame;
	end
endmodule
`default_nettype wire

// ---- testbench/usb_otg_common_control_bench.sv ----
`default_nettype none
module usb_otg_common_control_bench import uocc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, reset_n = 0, pkt = 0, zl = 0, snd = 0, ce = 1;
	uocc_bus_t bus = '0;
	uocc_link_t ev = '0, lv = '0, link_raw;
	logic [15:0] rdata, tx_ev = '0, rx_ev = '0;
	logic send_packet, send_zero_length, oe_n, susp_o, res_d, host, ovr, irq;
	logic [1:0] spd;
	logic [3:0] sel;
	int n_errors = 0, n_checks = 0;
	logic [9:0] ra[11] = '{OFF_POWER, OFF_TXE, OFF_RXE, OFF_USBE, OFF_VBUS_PULSE_DURATION, OFF_HSEOF,
		OFF_FSEOF, OFF_LSEOF, OFF_FRAME, OFF_INDEX, 10'h302};
	logic [15:0] rv[11] = '{16'h0020, 16'hffff, 16'hfffe, 16'h0006, 16'h003c, 16'h0080,
		16'h0077, 16'h0072, 16'h0000, 16'h0000, 16'h0000};
	logic [7:0] tm[3] = '{8'h80, 8'ha0, 8'h90};
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (send_zero_length === 1'b1) zl <= 1'b1;
		if (send_packet === 1'b1) snd <= 1'b1;
	end
	uocc_line_model far (.ref_clk(ref_clk), .reset_n(reset_n), .cmd(ev), .link_raw(link_raw));
	uocc_common_ctrl #(.RESUME_LIMIT(50)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(ce), .bus(bus), .rdata(rdata), .link_raw(link_raw), .tx_ep_event(tx_ev),
		.rx_ep_event(rx_ev), .id_pin_input(1'b1), .phy_host_detach_status(1'b0),
		.tx_packet_loaded(pkt), .send_packet(send_packet), .send_zero_length(send_zero_length),
		.dp_dm_oe_n(oe_n), .transceiver_suspend_output(susp_o), .resume_drive(res_d),
		.host_mode(host), .link_speed(spd), .endpoint_select(sel), .resume_overrun(ovr),
		.irq(irq));
	// --------
	// Bus access and compares
	// --------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask
	task rc(input logic [9:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task pulse(input uocc_link_t p);
		@(posedge ref_clk);
		ev <= lv | p;
		@(posedge ref_clk);
		ev <= lv;
		cyc(6);
	endtask
	task level;
		@(posedge ref_clk);
		ev <= lv;
		cyc(6);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		n_errors++;
		finish_test;
	end
	// --------
	// Scenarios
	// --------
	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 11; i++) rc(ra[i], rv[i]);
		chkb(oe_n, 1'b1);
		wr(OFF_RXE, 16'hffff);
		rc(OFF_RXE, 16'hfffe);
		wr(OFF_TXF, 16'hffff);
		rc(OFF_TXF, 16'h0000);
		wr(OFF_INDEX, 16'h001f);
		rc(OFF_INDEX, 16'h000f);
		chk({12'h0, sel}, 16'h000f);
		wr(OFF_USBE, 16'h00ff);
		rc(OFF_USBE, 16'h00ff);
		wr(10'h31e, 16'ha5c3);
		rc(10'h31e, 16'ha5c3);
		rc(10'h07f, 16'h0000);
		$display("test registers done");
		@(posedge ref_clk);
		tx_ev <= 16'h8001;
		rx_ev <= 16'hffff;
		@(posedge ref_clk);
		tx_ev <= '0;
		rx_ev <= '0;
		cyc(3);
		chkb(irq, 1'b1);
		rc(OFF_TXF, 16'h8001);
		rc(OFF_TXF, 16'h0000);
		rc(OFF_RXF, 16'hfffe);
		cyc(2);
		chkb(irq, 1'b0);
		$display("test endpoint flags done");
		@(posedge ref_clk);
		ce <= 1'b0;
		tx_ev <= 16'h0002;
		@(posedge ref_clk);
		ce <= 1'b1;
		tx_ev <= '0;
		rc(OFF_TXF, 16'h0000);
		$display("test clock enable done");
		wr(OFF_USBE, 16'h0000);
		pulse('{sof: 1'b1, default: '0});
		chkb(irq, 1'b0);
		wr(OFF_USBE, 16'h0008);
		cyc(2);
		chkb(irq, 1'b1);
		rc(OFF_USBF, 16'h0008);
		lv.frame = 11'h7ff;
		level;
		rc(OFF_FRAME, 16'h07ff);
		wr(OFF_SESSION, 16'h0001);
		lv.bus_reset = 1'b1;
		pulse('{hs_chirp_ok: 1'b1, default: '0});
		rc(OFF_POWER, 16'h0038);
		lv.bus_reset = 1'b0;
		level;
		rc(OFF_POWER, 16'h0030);
		rc(OFF_USBF, 16'h0004);
		$display("test bus events done");
		pulse('{suspend_seen: 1'b1, default: '0});
		chkb(susp_o, 1'b0);
		rc(OFF_POWER, 16'h0032);
		pulse('{resume_seen: 1'b1, default: '0});
		rc(OFF_USBF, 16'h0003);
		rc(OFF_POWER, 16'h0030);
		pulse('{suspend_seen: 1'b1, default: '0});
		wr(OFF_POWER, 16'h0024);
		cyc(2);
		chkb(res_d, 1'b1);
		rc(OFF_POWER, 16'h0034);
		wr(OFF_POWER, 16'h0060);
		cyc(2);
		chkb(res_d, 1'b0);
		chkb(ovr, 1'b0);
		chkb(oe_n, 1'b0);
		wr(OFF_POWER, 16'h00a0);
		cyc(2);
		chkb(oe_n, 1'b1);
		wr(OFF_POWER, 16'h0024);
		cyc(60);
		chkb(ovr, 1'b1);
		wr(OFF_POWER, 16'h00a0);
		$display("test power control done");
		pkt <= 1'b1;
		pulse('{in_token: 1'b1, default: '0});
		chkb(zl, 1'b1);
		chkb(snd, 1'b0);
		pulse('{sof: 1'b1, default: '0});
		chkb(snd, 1'b1);
		pkt <= 1'b0;
		rc(OFF_USBF, 16'h0009);
		lv.a_device = 1'b1;
		wr(OFF_SESSION, 16'h0001);
		pulse('{sess_req: 1'b1, default: '0});
		lv.vbus_low = 1'b1;
		level;
		rc(OFF_USBF, 16'h00c0);
		lv.vbus_low = 1'b0;
		lv.a_device = 1'b0;
		wr(OFF_SESSION, 16'h0000);
		level;
		$display("test iso and otg done");
		for (int i = 0; i < 3; i++) begin
			wr(OFF_TEST, {8'h00, tm[i]});
			wr(OFF_SESSION, 16'h0001);
			cyc(4);
			chkb(host, 1'b1);
			chk({14'h0, spd}, i[15:0]);
			wr(OFF_SESSION, 16'h0000);
			cyc(4);
			chkb(host, 1'b0);
		end
		$display("test forced host done");
		wr(OFF_SESSION, 16'h0001);
		pulse('{babble: 1'b1, default: '0});
		pulse('{attach: 1'b1, default: '0});
		rc(OFF_USBF, 16'h0090);
		pulse('{sof: 1'b1, default: '0});
		pulse('{babble: 1'b1, default: '0});
		pulse('{detach: 1'b1, default: '0});
		rc(OFF_USBF, 16'h002c);
		wr(OFF_POWER, 16'h0023);
		pulse('{resume_seen: 1'b1, default: '0});
		chkb(susp_o, 1'b1);
		rc(OFF_POWER, 16'h0027);
		rc(OFF_USBF, 16'h0002);
		cyc(2);
		chkb(susp_o, 1'b0);
		chkb(res_d, 1'b1);
		$display("test host events done");
		finish_test;
	end
endmodule
`default_nettype wire
